// *** hw/irq_accept_seq.sv ***
`timescale 1ns/1ps
// Behaviour
// - Global enable gates all maskable sources
// - Global enable resets to zero
// - Source request sets its pending bit
// - Pending bit cleared after acceptance
// - Eligible only if level above processor level
// - Three-bit level; zero disables, seven highest
// - Processor level n admits n+1 upward
// - Accept needs enable, pending, higher level
// - Enable, pending, levels, processor level independent
// - Arbitrate at instruction end, enter next cycle
// - Suspend string and accumulate instructions
// - Read info address, then clear request
// - Copy flags into hidden temporary register
// - Clear enable, debug, stack select flags (stack select kept for software numbers 20h to 3Fh)
// - Push saved flags, then program counter
// - Load processor level with accepted level (hardware sources only; software interrupts keep it)
// - Continue at interrupt routine start
// - Equal levels resolved by fixed priority
module irq_accept_seq
    import irq_accept_pkg::*;
#(
    parameter int N_SRC = 8
) (
    input  wire logic                   REF_CLK,
    input  wire logic                   RST_B,
    input  wire logic                   CLK_EN,
    // Peripheral request pulses
    input  wire logic [N_SRC-1:0]       SRC_REQ,
    // Software access to control fields
    input  wire logic [N_SRC-1:0]       PEND_CLR,
    input  wire logic                   LVL_WR,
    input  wire logic [$clog2(N_SRC)-1:0] LVL_IDX,
    input  wire logic [LVL_W-1:0]       LVL_DATA,
    input  wire logic                   FLG_WR,
    input  wire logic [FLG_W-1:0]       FLG_DATA,
    // Pipeline status
    input  wire logic                   INSTR_DONE,
    input  wire logic                   INSTR_SUSPENDABLE,
    input  wire logic                   SWI_REQ,
    input  wire logic [VEC_W-1:0]       SWI_NUM,
    input  wire logic [PC_W-1:0]        CUR_PC,
    input  wire logic [PC_W-1:0]        VEC_ADDR,
    input  wire logic                   BUS_ACK,
    // Outputs
    output logic [N_SRC-1:0]            PEND,
    output logic [N_SRC*LVL_W-1:0]      LEVELS,
    output logic [FLG_W-1:0]            FLAG_REGISTER,
    output logic                        IN_ENTRY,
    output logic                        SUSPEND,
    output logic                        INFO_RD,
    output logic [PC_W-1:0]             INFO_ADDR_OUT,
    output logic                        PUSH_VALID,
    output logic [FLG_W-1:0]            PUSH_FLG,
    output logic                        PUSH_IS_PC,
    output logic [PC_W-1:0]             PUSH_PC,
    output logic [VEC_W-1:0]            ACC_NUM,
    output logic                        FETCH_JUMP,
    output logic [PC_W-1:0]             FETCH_ADDR
);
    localparam int IW = $clog2(N_SRC);

    entry_state_t             state_ff, nxt_state;
    logic [N_SRC-1:0]         pend_ff, nxt_pend;
    logic [N_SRC*LVL_W-1:0]   lvl_ff;
    logic [FLG_W-1:0]         flg_ff, nxt_flg;
    logic [FLG_W-1:0]         tmp_flg_ff;
    logic [IW-1:0]            cap_idx_ff;
    logic [LVL_W-1:0]         cap_lvl_ff;
    logic                     cap_swi_ff;
    logic [VEC_W-1:0]         cap_num_ff;
    logic [PC_W-1:0]          pc_ff;
    logic                     push_v_ff, push_pc_ff;
    logic [FLG_W-1:0]         push_flg_ff;
    logic [PC_W-1:0]          push_pc_val_ff;
    logic                     jump_ff;
    logic [PC_W-1:0]          jump_addr_ff;

    logic                     found;
    logic [IW-1:0]            win_idx;
    logic [LVL_W-1:0]         win_lvl;
    logic                     gie;
    logic [LVL_W-1:0]         processor_priority_level;
    logic                     idle;
    logic                     take_hw;
    logic                     take_any;
    logic                     step;

    function automatic logic [FLG_W-1:0] set_ipl(
        input logic [FLG_W-1:0] f,
        input logic [LVL_W-1:0] l
    );
        logic [FLG_W-1:0] r;
        r = f;
        r[FLG_IPL_LO +: LVL_W] = l;
        return r;
    endfunction

    // Flag fields decoded once
    assign gie  = flg_ff[FLG_I_POS];
    assign processor_priority_level  = flg_ff[FLG_IPL_LO +: LVL_W];
    assign idle = (state_ff == ST_IDLE);

    irq_prio_arbiter #(
        .N_SRC (N_SRC)
    ) u_arb (
        .pend    (pend_ff),
        .levels  (lvl_ff),
        .processor_priority_level     (processor_priority_level),
        .gie     (gie),
        .found   (found),
        .win_idx (win_idx),
        .win_lvl (win_lvl)
    );

    // Sample only at an instruction boundary or a suspendable point
    assign take_hw  = idle && found
                      && (INSTR_DONE || INSTR_SUSPENDABLE);
    assign take_any = idle && (SWI_REQ && INSTR_DONE || take_hw);
    // Bus steps wait on acknowledge, internal steps do not
    assign step = (state_ff == ST_INFO || state_ff == ST_PUSHF
                   || state_ff == ST_PUSHP) ? BUS_ACK : 1'b1;

    // Entry walk
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:  if (take_any) nxt_state = ST_INFO;
            ST_INFO:  if (step) nxt_state = ST_SAVE;
            ST_SAVE:  nxt_state = ST_CLEAR;
            ST_CLEAR: nxt_state = ST_PUSHF;
            ST_PUSHF: if (step) nxt_state = ST_PUSHP;
            ST_PUSHP: if (step) nxt_state = ST_LDIPL;
            ST_LDIPL: nxt_state = ST_JUMP;
            ST_JUMP:  nxt_state = ST_IDLE;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    // Pending: set wins over any clear in the same cycle
    always_comb begin
        nxt_pend = pend_ff & ~PEND_CLR;
        if (state_ff == ST_INFO && step && !cap_swi_ff) begin
            nxt_pend[cap_idx_ff] = 1'b0;
        end
        nxt_pend = nxt_pend | SRC_REQ;
    end

    // Flag updates: software write, clear step, level load
    always_comb begin
        nxt_flg = FLG_WR ? FLG_DATA : flg_ff;
        if (state_ff == ST_CLEAR) begin
            nxt_flg[FLG_I_POS] = 1'b0;
            nxt_flg[FLG_D_POS] = 1'b0;
            if (!(cap_swi_ff && cap_num_ff >= SWI_KEEP_LO
                  && cap_num_ff <= SWI_KEEP_HI)) begin
                nxt_flg[FLG_U_POS] = 1'b0;
            end
        end
        if (state_ff == ST_LDIPL && !cap_swi_ff) begin
            nxt_flg = set_ipl(nxt_flg, cap_lvl_ff);
        end
    end

    // State and sticky control
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_ff <= ST_IDLE;
            pend_ff  <= '0;
            flg_ff   <= FLG_RESET;
        end else if (CLK_EN) begin
            state_ff <= nxt_state;
            pend_ff  <= nxt_pend;
            flg_ff   <= nxt_flg;
        end
    end

    // Level fields, written one source at a time
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            lvl_ff <= '0;
        end else if (CLK_EN && LVL_WR) begin
            lvl_ff[LVL_IDX*LVL_W +: LVL_W] <= LVL_DATA;
        end
    end

    // Winner frozen at acceptance so later requests cannot disturb it
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cap_idx_ff <= '0;
            cap_lvl_ff <= LVL_DISABLED;
            cap_swi_ff <= 1'b0;
            cap_num_ff <= '0;
            pc_ff      <= '0;
        end else if (CLK_EN && take_any) begin
            cap_idx_ff <= win_idx;
            cap_lvl_ff <= win_lvl;
            cap_swi_ff <= !take_hw;
            cap_num_ff <= take_hw ? VEC_W'(win_idx) : SWI_NUM;
            pc_ff      <= CUR_PC;
        end
    end

    // Hidden copy of flags as they stood before entry
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tmp_flg_ff <= FLG_RESET;
        end else if (CLK_EN && state_ff == ST_SAVE) begin
            tmp_flg_ff <= flg_ff;
        end
    end

    // Push data held steady from flops while the bus waits
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            push_v_ff      <= 1'b0;
            push_pc_ff     <= 1'b0;
            push_flg_ff    <= FLG_RESET;
            push_pc_val_ff <= '0;
        end else if (CLK_EN) begin
            push_v_ff      <= (nxt_state == ST_PUSHF)
                              || (nxt_state == ST_PUSHP);
            push_pc_ff     <= (nxt_state == ST_PUSHP);
            push_flg_ff    <= tmp_flg_ff;
            push_pc_val_ff <= pc_ff;
        end
    end

    // Redirect fetch to the routine once entry ends
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            jump_ff      <= 1'b0;
            jump_addr_ff <= '0;
        end else if (CLK_EN) begin
            jump_ff      <= (state_ff == ST_JUMP);
            jump_addr_ff <= VEC_ADDR;
        end
    end

    // Output drive
    assign PEND          = pend_ff;
    assign LEVELS        = lvl_ff;
    assign FLAG_REGISTER           = flg_ff;
    assign IN_ENTRY      = !idle;
    // Only flag a suspension on a cycle that really advances the walk
    assign SUSPEND       = take_hw && !INSTR_DONE && CLK_EN;
    assign INFO_RD       = (state_ff == ST_INFO);
    assign INFO_ADDR_OUT = INFO_ADDR;
    assign PUSH_VALID    = push_v_ff;
    assign PUSH_IS_PC    = push_pc_ff;
    assign PUSH_FLG      = push_flg_ff;
    assign PUSH_PC       = push_pc_val_ff;
    assign ACC_NUM       = cap_num_ff;
    assign FETCH_JUMP    = jump_ff;
    assign FETCH_ADDR    = jump_addr_ff;
endmodule

// *** hw/irq_prio_arbiter.sv ***
`timescale 1ns/1ps
// Picks the highest eligible level; ties go to the lower source index,
// which is taken as the higher fixed hardware priority.
module irq_prio_arbiter
    import irq_accept_pkg::*;
#(
    parameter int N_SRC = 8
) (
    input  wire logic [N_SRC-1:0]       pend,
    input  wire logic [N_SRC*LVL_W-1:0] levels,
    input  wire logic [LVL_W-1:0]       processor_priority_level,
    input  wire logic                   gie,
    output logic                        found,
    output logic [$clog2(N_SRC)-1:0]    win_idx,
    output logic [LVL_W-1:0]            win_lvl
);
    localparam int IW = $clog2(N_SRC);

    // Scan from the lowest priority upward so the last hit wins
    always_comb begin
        found   = 1'b0;
        win_idx = '0;
        win_lvl = LVL_DISABLED;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (gie && pend[i]
                && levels[i*LVL_W +: LVL_W] > processor_priority_level
                && (!found || levels[i*LVL_W +: LVL_W] >= win_lvl)) begin
                found   = 1'b1;
                win_idx = IW'(i);
                win_lvl = levels[i*LVL_W +: LVL_W];
            end
        end
    end
endmodule

// *** shared/irq_accept_pkg.sv ***
package irq_accept_pkg;
    localparam int  LVL_W       = 3;
    localparam logic [2:0] LVL_DISABLED = 3'h0;
    localparam int  FLG_W       = 16;
    localparam int  PC_W        = 20;
    localparam int  VEC_W       = 6;
    // Flag register bit positions
    localparam int  FLG_D_POS   = 2;
    localparam int  FLG_U_POS   = 7;
    localparam int  FLG_I_POS   = 6;
    localparam int  FLG_IPL_LO  = 12;
    localparam logic [FLG_W-1:0] FLG_RESET = 16'h0000;
    // Fixed address read to fetch interrupt information
    localparam logic [PC_W-1:0] INFO_ADDR = 20'h00000;
    // Software interrupt numbers that keep the stack select flag
    localparam logic [VEC_W-1:0] SWI_KEEP_LO = 6'h20;
    localparam logic [VEC_W-1:0] SWI_KEEP_HI = 6'h3F;

    // Gray coded along the entry path
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_INFO  = 3'b001,
        ST_SAVE  = 3'b011,
        ST_CLEAR = 3'b010,
        ST_PUSHF = 3'b110,
        ST_PUSHP = 3'b111,
        ST_LDIPL = 3'b101,
        ST_JUMP  = 3'b100
    } entry_state_t;
endpackage

// *** testbench/bus_ack_model.sv ***
`timescale 1ns/1ps
// Memory side of entry: answers the info read and both pushes
module bus_ack_model (
    input  wire logic REF_CLK,
    input  wire logic RST_B,
    input  wire logic CLK_EN,
    input  wire logic INFO_RD,
    input  wire logic PUSH_VALID,
    input  wire logic PUSH_IS_PC,
    input  wire logic SLOW,
    output logic      BUS_ACK
);
    logic [2:0] key_ff;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    wire  [2:0] key = {INFO_RD, PUSH_VALID, PUSH_IS_PC};
    wire  [2:0] need = SLOW ? 3'h5 : 3'h2;
    // Never answer a fresh request, so the lagging copy of a push
    // is not mistaken for a second transfer
    assign BUS_ACK = (INFO_RD || PUSH_VALID) && key == key_ff
                     && cnt_ff >= need;
    assign nxt_cnt = (BUS_ACK || key != key_ff) ? 3'h0
                     : cnt_ff + {2'h0, cnt_ff != 3'h7};
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            key_ff <= 3'h0;
            cnt_ff <= 3'h0;
        end else if (CLK_EN) begin
            key_ff <= key;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

// *** testbench/irq_accept_seq_properties.sv ***
`timescale 1ns/1ps
module irq_accept_seq_properties
    import irq_accept_pkg::*;
(
    input wire logic             REF_CLK,
    input wire logic             RST_B,
    input wire logic             CLK_EN,
    input wire logic             INSTR_DONE,
    input wire logic             INSTR_SUSPENDABLE,
    input wire logic             SWI_REQ,
    input wire logic             BUS_ACK,
    input wire logic [PC_W-1:0]  VEC_ADDR,
    input wire logic [FLG_W-1:0] FLAG_REGISTER,
    input wire logic             IN_ENTRY,
    input wire logic             SUSPEND,
    input wire logic             INFO_RD,
    input wire logic [PC_W-1:0]  INFO_ADDR_OUT,
    input wire logic             PUSH_VALID,
    input wire logic [FLG_W-1:0] PUSH_FLG,
    input wire logic             PUSH_IS_PC,
    input wire logic             FETCH_JUMP,
    input wire logic [PC_W-1:0]  FETCH_ADDR
);
    logic [FLG_W-1:0] idle_flg_ff;
    // Flags seen while idle; entry must push exactly these
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B)
            idle_flg_ff <= FLG_RESET;
        else if (!IN_ENTRY)
            idle_flg_ff <= FLAG_REGISTER;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_flag_ack;
        PUSH_VALID && !PUSH_IS_PC && BUS_ACK && CLK_EN;
    endsequence
    sequence s_pc_push;
        PUSH_VALID && PUSH_IS_PC;
    endsequence
    // Only a software interrupt may enter with the enable low
    a_gate_global: assert property (
        !IN_ENTRY && !FLAG_REGISTER[FLG_I_POS] && !SWI_REQ |=> !IN_ENTRY)
        else $error("entry with enable low");
    a_instr_boundary: assert property (
        !IN_ENTRY && !INSTR_DONE && !INSTR_SUSPENDABLE |=> !IN_ENTRY)
        else $error("entry inside an instruction");
    a_suspend_entry: assert property (
        SUSPEND |-> CLK_EN && INSTR_SUSPENDABLE ##1 INFO_RD)
        else $error("suspend without entry");
    a_info_first: assert property (
        $rose(IN_ENTRY) |-> INFO_RD && INFO_ADDR_OUT == INFO_ADDR)
        else $error("entry did not start with info read");
    a_saved_flags: assert property (
        PUSH_VALID && !PUSH_IS_PC |-> PUSH_FLG == idle_flg_ff)
        else $error("pushed flags differ");
    a_clear_flags: assert property (
        INFO_RD && BUS_ACK && CLK_EN |-> ##[2:8]
        (!FLAG_REGISTER[FLG_I_POS] && !FLAG_REGISTER[FLG_D_POS]))
        else $error("enable or debug flag kept");
    a_push_order: assert property (
        s_flag_ack |-> ##[1:4] s_pc_push)
        else $error("pc push missing after flags");
    a_jump_target: assert property (
        FETCH_JUMP |-> FETCH_ADDR == $past(VEC_ADDR) ##1 !FETCH_JUMP)
        else $error("bad jump");
endmodule
bind irq_accept_seq irq_accept_seq_properties u_props (
    .REF_CLK, .RST_B, .CLK_EN, .INSTR_DONE, .INSTR_SUSPENDABLE,
    .SWI_REQ, .BUS_ACK, .VEC_ADDR, .FLAG_REGISTER, .IN_ENTRY, .SUSPEND,
    .INFO_RD, .INFO_ADDR_OUT, .PUSH_VALID, .PUSH_FLG, .PUSH_IS_PC,
    .FETCH_JUMP, .FETCH_ADDR
);

// *** testbench/tb_maskable_interrupt_accept_sequencer.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin $display("wrong value %s expected %0h seen %0h", nm, e, g); miscompares++; end end
module tb_maskable_interrupt_accept_sequencer
    import irq_accept_pkg::*;
;
    logic REF_CLK = 1'b0, RST_B = 1'b0, CLK_EN = 1'b1, LVL_WR = 1'b0;
    logic FLG_WR = 1'b0, INSTR_DONE = 1'b0, INSTR_SUSPENDABLE = 1'b0;
    logic SWI_REQ = 1'b0, SLOW = 1'b0, BUS_ACK, IN_ENTRY, SUSPEND;
    logic INFO_RD, PUSH_VALID, PUSH_IS_PC, FETCH_JUMP;
    logic [3:0] SRC_REQ = 4'h0, PEND_CLR = 4'h0, PEND;
    logic [1:0] LVL_IDX = 2'h0, a, b, win;
    logic [2:0] LVL_DATA = 3'h0, la, lb, hi, processor_priority_level;
    logic [11:0] LEVELS;
    logic [FLG_W-1:0] FLG_DATA = 16'h0000, FLAG_REGISTER, PUSH_FLG;
    logic [VEC_W-1:0] SWI_NUM = 6'h00, ACC_NUM;
    logic [PC_W-1:0] CUR_PC = 20'h12345, VEC_ADDR = 20'h0ABC0;
    logic [PC_W-1:0] INFO_ADDR_OUT, PUSH_PC, FETCH_ADDR, seen_pc;
    logic [7:0] rnd = 8'h18;
    logic take, en;
    int miscompares = 0, checks = 0;
    irq_accept_seq #(.N_SRC(4)) dut (.REF_CLK, .RST_B, .CLK_EN,
        .SRC_REQ, .PEND_CLR, .LVL_WR, .LVL_IDX, .LVL_DATA, .FLG_WR,
        .FLG_DATA, .INSTR_DONE, .INSTR_SUSPENDABLE, .SWI_REQ, .SWI_NUM,
        .CUR_PC, .VEC_ADDR, .BUS_ACK, .PEND, .LEVELS, .FLAG_REGISTER, .IN_ENTRY,
        .SUSPEND, .INFO_RD, .INFO_ADDR_OUT, .PUSH_VALID, .PUSH_FLG,
        .PUSH_IS_PC, .PUSH_PC, .ACC_NUM, .FETCH_JUMP, .FETCH_ADDR);
    bus_ack_model partner (.REF_CLK, .RST_B, .CLK_EN, .INFO_RD,
        .PUSH_VALID, .PUSH_IS_PC, .SLOW, .BUS_ACK);
    always #2 REF_CLK = ~REF_CLK;
    // Counter value taken by the memory side on the second push
    always @(posedge REF_CLK)
        if (PUSH_VALID && PUSH_IS_PC && BUS_ACK && CLK_EN)
            seen_pc <= PUSH_PC;
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task set_lvl(input logic [1:0] i, input logic [2:0] l);
        @(posedge REF_CLK);
        LVL_WR <= 1'b1;
        LVL_IDX <= i;
        LVL_DATA <= l;
        @(posedge REF_CLK);
        LVL_WR <= 1'b0;
    endtask
    task set_flg(input logic [FLG_W-1:0] f);
        @(posedge REF_CLK);
        FLG_WR <= 1'b1;
        FLG_DATA <= f;
        @(posedge REF_CLK);
        FLG_WR <= 1'b0;
    endtask
    // Bounded wait for the jump into the routine
    task wait_jump;
        for (int n = 0; n < 80; n++) begin
            @(posedge REF_CLK);
            if (FETCH_JUMP === 1'b1)
                return;
        end
        miscompares++;
        end_of_test;
    endtask
    initial begin
        repeat (5) @(posedge REF_CLK);
        RST_B <= 1'b1;
        @(posedge REF_CLK);
        `CHK("flags", FLG_RESET, FLAG_REGISTER)
        for (int it = 0; it < 40; it++) begin
            rnd = lfsr(rnd);
            {lb, la, a} = rnd;
            rnd = lfsr(rnd);
            {processor_priority_level, b} = rnd[4:0];
            // First passes sweep every processor level, with source a's level la set to seven minus it
            if (it < 8) {processor_priority_level, la} = {it[2:0], 3'h7 - it[2:0]};
            if (b == a) b = a + 2'h1;
            en = (it % 5 != 4);
            hi = (la > lb) ? la : lb;
            win = (la > lb) ? a : (lb > la) ? b : (a < b) ? a : b;
            take = en && hi > processor_priority_level;
            set_lvl(a, la);
            set_lvl(b, lb);
            // Levels land at least two cycles before enable is written
            set_flg({1'b0, processor_priority_level, 5'h01, en, 3'h0, 1'b1, 2'h0});
            SRC_REQ <= (4'h1 << a) | (4'h1 << b);
            SLOW <= rnd[7];
            @(posedge REF_CLK);
            SRC_REQ <= 4'h0;
            @(posedge REF_CLK);
            `CHK("pend", 2'h3, {PEND[a], PEND[b]})
            `CHK("level", la, LEVELS[3*a +: 3])
            INSTR_DONE <= !rnd[5];
            INSTR_SUSPENDABLE <= rnd[5];
            CLK_EN <= !rnd[6];
            @(posedge REF_CLK);
            CLK_EN <= 1'b1;
            if (take) begin
                wait_jump;
                `CHK("ipl", hi, FLAG_REGISTER[14:12])
                `CHK("flags", 3'h0, {FLAG_REGISTER[7:6], FLAG_REGISTER[2]})
                `CHK("winner", 1'b0, PEND[win])
                `CHK("loser", 1'b1, PEND[a ^ b ^ win])
                `CHK("number", {4'h0, win}, ACC_NUM)
                `CHK("pushed pc", CUR_PC, seen_pc)
                `CHK("vector", VEC_ADDR, FETCH_ADDR)
            end else begin
                repeat (12) @(posedge REF_CLK);
                `CHK("blocked", 4'b0011, {IN_ENTRY, FETCH_JUMP,
                     PEND[a], PEND[b]})
            end
            INSTR_DONE <= 1'b0;
            INSTR_SUSPENDABLE <= 1'b0;
            PEND_CLR <= 4'hF;
            @(posedge REF_CLK);
            PEND_CLR <= 4'h0;
            @(posedge REF_CLK);
            `CHK("cleared", 4'h0, PEND)
        end
        // Software interrupts either side of the stack-select boundary
        for (int k = 0; k < 3; k++) begin
            set_flg(16'h70C0);
            SWI_NUM <= (k == 0) ? 6'h1F : (k == 1) ? 6'h20 : 6'h3F;
            SWI_REQ <= 1'b1;
            INSTR_DONE <= 1'b1;
            @(posedge REF_CLK);
            SWI_REQ <= 1'b0;
            INSTR_DONE <= 1'b0;
            wait_jump;
            `CHK("stack select", k != 0, FLAG_REGISTER[FLG_U_POS])
            `CHK("swi ipl", 3'h7, FLAG_REGISTER[14:12])
            `CHK("swi number", SWI_NUM, ACC_NUM)
        end
        end_of_test;
    end
endmodule
